// File: mac_12x12_accumulator.sv
// Top level of the 12x12 multiplier-accumulator with preload
//
// Behaviour
// [RULE1] Operand X captured on multiplicand clock rise, Y on multiplier clock rise
// [RULE2] Accumulate select high: combine register with new product
// [RULE3] Accumulate select low: product loads register directly
// [RULE4] Accumulate select registered on either input clock rise
// [RULE5] Accumulate and difference high: product minus register, stored on result clock
// [RULE6] Accumulate high, difference low: product plus register
// [RULE7] Difference select registered on either clock, ignored without accumulate
// [RULE8] Signed select picks two's complement or unsigned operands
// [RULE9] Round select adds one at lower section top bit
// [RULE10] Round select registered on either input clock rise
// [RULE11] Host holds selects stable with operand set-up and hold
// [RULE12] Preload high forces all result sections undriven
// [RULE13] Preload high: sections with disable high load from pins
// [RULE14] Host drives preload data and holds controls around result clock
// [RULE15] Disable controls act combinationally; high disables, low enables
// [RULE16] Preload low, disable low: section drives register contents
// [RULE17] Result register loads computed value every result clock rise
// [RULE18] Result split into 3 guard, 12 upper, 12 lower bits
// [RULE19] Signed multiply sign-extends; -1 times -1 gives plus one
// [RULE20] Accumulation is full 27 bits with three guard bits
// [RULE21] Unsigned multiply zero-extends; accumulation wraps modulo 2^27
// [RULE22] Product uses operands and selects from latest input clock edges
`timescale 1ns/10ps
`default_nettype none
module mac_12x12_accumulator
#(
    parameter int OPERAND_W = mac_pkg::OPERAND_W
)
(
    // System clock and reset
    input  wire logic                         i_clock,
    input  wire logic                         i_rst_b,
    // Pin clocks, sampled in the system clock domain
    input  wire logic                         i_multiplicand_clock,
    input  wire logic                         i_multiplier_clock,
    input  wire logic                         i_result_clock,
    // Operands
    input  wire logic [OPERAND_W-1:0]         i_multiplicand,
    input  wire logic [OPERAND_W-1:0]         i_multiplier,
    // Operation selects
    input  wire logic                         i_sum_mode_select,
    input  wire logic                         i_diff_select,
    input  wire logic                         i_round_up_select,
    input  wire logic                         i_signed_select,
    // Output section controls
    input  wire logic                         i_pin_load_mode,
    input  wire logic                         i_guard_out_disable,
    input  wire logic                         i_upper_out_disable,
    input  wire logic                         i_lower_out_disable,
    // Result pins, split into input, output and enable (low = driving)
    input  wire logic [mac_pkg::RESULT_W-1:0] i_result_pins,
    output logic      [mac_pkg::RESULT_W-1:0] o_result,
    output logic      [mac_pkg::RESULT_W-1:0] o_result_oe_b
);
    mac_op_if op ();

    typedef logic [mac_pkg::RESULT_W-1:0] result_t;

    logic                         x_rise;
    logic                         y_rise;
    logic                         p_rise;
    logic                         any_in_rise;
    logic [OPERAND_W-1:0]         x_reg;
    logic [OPERAND_W-1:0]         y_reg;
    logic                         sum_reg;
    logic                         diff_reg;
    logic                         round_reg;
    logic                         signed_reg;
    logic [mac_pkg::RESULT_W-1:0] result_reg;
    logic [mac_pkg::RESULT_W-1:0] result_next;
    logic [mac_pkg::RESULT_W-1:0] load_mask;
    logic                         guard_drive;
    logic                         upper_drive;
    logic                         lower_drive;
    result_t                      check_prod;
    logic [mac_pkg::GUARD_W:0]    sign_top;

    // Edge detection of the three pin clocks
    mac_sync u_sync_x
    (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_pin   (i_multiplicand_clock),
        .o_level (),
        .o_rise  (x_rise)
    );
    mac_sync u_sync_y
    (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_pin   (i_multiplier_clock),
        .o_level (),
        .o_rise  (y_rise)
    );
    mac_sync u_sync_p
    (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_pin   (i_result_clock),
        .o_level (),
        .o_rise  (p_rise)
    );

    assign any_in_rise = x_rise | y_rise;

    // Operand registers; data sampled late, so host must hold it [RULE11]
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            x_reg <= '0;
            y_reg <= '0;
        end
        else
        begin
            if (x_rise)
                x_reg <= i_multiplicand;   // [RULE1]
            if (y_rise)
                y_reg <= i_multiplier;     // [RULE1]
        end
    end

    // Selects load on either input clock rise [RULE4] [RULE7] [RULE10]
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sum_reg    <= 1'b0;
            diff_reg   <= 1'b0;
            round_reg  <= 1'b0;
            signed_reg <= 1'b0;
        end
        else if (any_in_rise)
        begin
            sum_reg    <= i_sum_mode_select;
            diff_reg   <= i_diff_select;
            round_reg  <= i_round_up_select;
            signed_reg <= i_signed_select;
        end
    end

    // Arithmetic sees latest registered operands and selects [RULE22]
    assign op.multiplicand = x_reg;
    assign op.multiplier   = y_reg;
    assign op.sum_mode     = sum_reg;
    assign op.diff_mode    = diff_reg;
    assign op.round_up     = round_reg;
    assign op.signed_mode  = signed_reg;
    assign op.acc_value    = result_reg;

    mac_arith u_arith
    (
        .op (op)
    );

    // Per-bit preload mask from the section controls [RULE13] [RULE18]
    function automatic logic [mac_pkg::RESULT_W-1:0] section_mask
    (
        input logic g,
        input logic u,
        input logic l
    );
        section_mask = {{mac_pkg::GUARD_W{g}}, {mac_pkg::UPPER_W{u}},
                        {mac_pkg::LOWER_W{l}}};
    endfunction

    assign load_mask = section_mask(i_guard_out_disable,
                                    i_upper_out_disable,
                                    i_lower_out_disable);

    // Preload merges pins into sections with disable high, keeps the rest
    assign result_next = i_pin_load_mode
        ? ((i_result_pins & load_mask) | (result_reg & ~load_mask)) // [RULE13]
        : op.next_value;                                            // [RULE17]

    // Result register, updated only on result clock rise [RULE5] [RULE17]
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
            result_reg <= mac_pkg::RESULT_RESET;
        else if (p_rise)
            result_reg <= result_next;
    end

    // Unregistered drive enables; preload overrides everything
    assign guard_drive = ~i_pin_load_mode & ~i_guard_out_disable; // [RULE12] [RULE15]
    assign upper_drive = ~i_pin_load_mode & ~i_upper_out_disable; // [RULE12] [RULE15]
    assign lower_drive = ~i_pin_load_mode & ~i_lower_out_disable; // [RULE12] [RULE15]

    // Data always shows the register; enable low means driving [RULE16]
    assign o_result      = result_reg;
    assign o_result_oe_b = ~section_mask(guard_drive, upper_drive,
                                         lower_drive);           // [RULE18]

    // Checker-only product, formed apart from the arithmetic stage so a
    // fault in its operand extension cannot hide behind itself
    assign check_prod = signed_reg
        ? result_t'($signed(x_reg)) * result_t'($signed(y_reg)) // [RULE8]
        : result_t'(x_reg) * result_t'(y_reg);                  // [RULE8]
    assign sign_top   = result_reg[mac_pkg::RESULT_W-1 -: mac_pkg::GUARD_W+1];

    // Drive enable checks, all combinational
    chk_preload_hiz: assert property ( // [RULE12]
        @(posedge i_clock) disable iff (!i_rst_b)
        i_pin_load_mode |-> (&o_result_oe_b))
        else $error("preload did not release result pins");

    chk_lower_enable: assert property ( // [RULE15]
        @(posedge i_clock) disable iff (!i_rst_b)
        (!i_pin_load_mode && !i_lower_out_disable)
        |-> o_result_oe_b[mac_pkg::LOWER_LSB] == 1'h0)
        else $error("lower section not driven when enabled");

    chk_upper_enable: assert property ( // [RULE16]
        @(posedge i_clock) disable iff (!i_rst_b)
        (!i_pin_load_mode && !i_upper_out_disable)
        |-> o_result_oe_b[mac_pkg::UPPER_LSB] == 1'h0)
        else $error("upper section not driven when enabled");

    chk_guard_enable: assert property ( // [RULE15]
        @(posedge i_clock) disable iff (!i_rst_b)
        (!i_pin_load_mode && !i_guard_out_disable)
        |-> o_result_oe_b[mac_pkg::GUARD_LSB] == 1'h0)
        else $error("guard section not driven when enabled");

    chk_guard_disable: assert property ( // [RULE15]
        @(posedge i_clock) disable iff (!i_rst_b)
        i_guard_out_disable |-> o_result_oe_b[mac_pkg::GUARD_LSB])
        else $error("guard section driven while disabled");

    chk_upper_disable: assert property ( // [RULE15]
        @(posedge i_clock) disable iff (!i_rst_b)
        i_upper_out_disable |-> o_result_oe_b[mac_pkg::UPPER_LSB])
        else $error("upper section driven while disabled");

    chk_lower_disable: assert property ( // [RULE15]
        @(posedge i_clock) disable iff (!i_rst_b)
        i_lower_out_disable |-> o_result_oe_b[mac_pkg::LOWER_LSB])
        else $error("lower section driven while disabled");

    // Result register checks; all but the hold and extension checks use the checker-only product
    chk_hold_no_clock: assert property ( // [RULE17]
        @(posedge i_clock) disable iff (!i_rst_b)
        !p_rise |=> $stable(result_reg))
        else $error("result changed without result clock");

    chk_multiply_load: assert property ( // [RULE3]
        @(posedge i_clock) disable iff (!i_rst_b)
        (p_rise && !i_pin_load_mode && !sum_reg && !round_reg)
        |=> result_reg == $past(check_prod))
        else $error("plain product not loaded");

    chk_sum_add: assert property ( // [RULE6]
        @(posedge i_clock) disable iff (!i_rst_b)
        (p_rise && !i_pin_load_mode && sum_reg && !diff_reg && !round_reg)
        |=> result_reg == $past(check_prod) + $past(result_reg))
        else $error("accumulate result not stored");

    chk_sum_sub: assert property ( // [RULE5]
        @(posedge i_clock) disable iff (!i_rst_b)
        (p_rise && !i_pin_load_mode && sum_reg && diff_reg && !round_reg)
        |=> result_reg == $past(check_prod) - $past(result_reg))
        else $error("difference result not stored");

    chk_diff_ignored: assert property ( // [RULE7]
        @(posedge i_clock) disable iff (!i_rst_b)
        (p_rise && !i_pin_load_mode && !sum_reg && diff_reg && !round_reg)
        |=> result_reg == $past(check_prod))
        else $error("difference applied without accumulate");

    chk_round_add: assert property ( // [RULE9]
        @(posedge i_clock) disable iff (!i_rst_b)
        (p_rise && !i_pin_load_mode && !sum_reg && round_reg)
        |=> result_reg == $past(check_prod) + mac_pkg::ROUND_ADD)
        else $error("rounded product not stored");

    chk_sign_extend: assert property ( // [RULE19]
        @(posedge i_clock) disable iff (!i_rst_b)
        (p_rise && !i_pin_load_mode && !sum_reg && !round_reg && signed_reg)
        |=> (&sign_top) || !(|sign_top))
        else $error("signed product not sign extended");

    chk_unsigned_guard: assert property ( // [RULE21]
        @(posedge i_clock) disable iff (!i_rst_b)
        (p_rise && !i_pin_load_mode && !sum_reg && !round_reg
         && !signed_reg)
        |=> result_reg[mac_pkg::GUARD_LSB +: mac_pkg::GUARD_W] == '0)
        else $error("unsigned product guard bits not zero");

    // Preload checks, load for every section, keep for upper and lower only
    chk_preload_keep: assert property ( // [RULE13]
        @(posedge i_clock) disable iff (!i_rst_b)
        (p_rise && i_pin_load_mode && !i_upper_out_disable)
        |=> result_reg[mac_pkg::UPPER_LSB +: mac_pkg::UPPER_W]
            == $past(result_reg[mac_pkg::UPPER_LSB +: mac_pkg::UPPER_W]))
        else $error("unselected section changed in preload");

    chk_preload_load: assert property ( // [RULE13]
        @(posedge i_clock) disable iff (!i_rst_b)
        (p_rise && i_pin_load_mode && i_lower_out_disable)
        |=> result_reg[mac_pkg::LOWER_LSB +: mac_pkg::LOWER_W]
            == $past(i_result_pins[mac_pkg::LOWER_LSB +: mac_pkg::LOWER_W]))
        else $error("selected section not preloaded");

    chk_preload_upper: assert property ( // [RULE13]
        @(posedge i_clock) disable iff (!i_rst_b)
        (p_rise && i_pin_load_mode && i_upper_out_disable)
        |=> result_reg[mac_pkg::UPPER_LSB +: mac_pkg::UPPER_W]
            == $past(i_result_pins[mac_pkg::UPPER_LSB +: mac_pkg::UPPER_W]))
        else $error("upper section not preloaded");

    chk_preload_guard: assert property ( // [RULE13]
        @(posedge i_clock) disable iff (!i_rst_b)
        (p_rise && i_pin_load_mode && i_guard_out_disable)
        |=> result_reg[mac_pkg::GUARD_LSB +: mac_pkg::GUARD_W]
            == $past(i_result_pins[mac_pkg::GUARD_LSB +: mac_pkg::GUARD_W]))
        else $error("guard section not preloaded");

    chk_lower_keep: assert property ( // [RULE13]
        @(posedge i_clock) disable iff (!i_rst_b)
        (p_rise && i_pin_load_mode && !i_lower_out_disable)
        |=> result_reg[mac_pkg::LOWER_LSB +: mac_pkg::LOWER_W]
            == $past(result_reg[mac_pkg::LOWER_LSB +: mac_pkg::LOWER_W]))
        else $error("lower section changed in preload");

    // Capture checks on the synchronised input clock pulses
    chk_select_capture: assert property ( // [RULE4]
        @(posedge i_clock) disable iff (!i_rst_b)
        any_in_rise |=> sum_reg == $past(i_sum_mode_select)
                        && round_reg == $past(i_round_up_select))
        else $error("selects not captured on input clock");

    chk_other_selects: assert property ( // [RULE7]
        @(posedge i_clock) disable iff (!i_rst_b)
        any_in_rise |=> diff_reg == $past(i_diff_select)
                        && signed_reg == $past(i_signed_select))
        else $error("difference or signed select not captured");

    chk_operand_x: assert property ( // [RULE1]
        @(posedge i_clock) disable iff (!i_rst_b)
        x_rise |=> x_reg == $past(i_multiplicand))
        else $error("multiplicand not captured");

    chk_operand_y: assert property ( // [RULE1]
        @(posedge i_clock) disable iff (!i_rst_b)
        y_rise |=> y_reg == $past(i_multiplier))
        else $error("multiplier not captured");

    chk_select_hold: assert property ( // [RULE4]
        @(posedge i_clock) disable iff (!i_rst_b)
        !any_in_rise |=> $stable(sum_reg) && $stable(diff_reg)
                         && $stable(round_reg) && $stable(signed_reg))
        else $error("selects changed without input clock");
endmodule
`default_nettype wire

// File: mac_pkg.sv
// Shared constants for the 12x12 multiplier-accumulator
`default_nettype none
package mac_pkg;
    localparam int OPERAND_W = 12;
    localparam int PRODUCT_W = 24;
    localparam int RESULT_W  = 27;
    localparam int GUARD_W   = 3;
    localparam int UPPER_W   = 12;
    localparam int LOWER_W   = 12;
    // Section positions inside the result word
    localparam int LOWER_LSB = 0;
    localparam int UPPER_LSB = 12;
    localparam int GUARD_LSB = 24;
    // Rounding adds one at the top bit of the lower section
    localparam int ROUND_BIT = 11;
    // Synchroniser depth for pin clocks
    localparam int SYNC_DEPTH = 3;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 27'h0000000;
    localparam logic [RESULT_W-1:0] ROUND_ADD    = 27'h0000800;
endpackage
`default_nettype wire

// File: mac_op_if.sv
// Operand and control bundle between capture and arithmetic stages
`timescale 1ns/10ps
`default_nettype none
interface mac_op_if;
    logic [mac_pkg::OPERAND_W-1:0] multiplicand;
    logic [mac_pkg::OPERAND_W-1:0] multiplier;
    logic                          sum_mode;
    logic                          diff_mode;
    logic                          round_up;
    logic                          signed_mode;
    logic [mac_pkg::RESULT_W-1:0]  acc_value;
    logic [mac_pkg::RESULT_W-1:0]  next_value;
    modport capture (output multiplicand, multiplier, sum_mode, diff_mode,
                     round_up, signed_mode);
    modport arith (input multiplicand, multiplier, sum_mode, diff_mode,
                   round_up, signed_mode, acc_value, output next_value);
    modport store (input next_value, output acc_value);
endinterface
`default_nettype wire

// File: mac_arith.sv
// Combinational product, accumulate, subtract and round stage
`timescale 1ns/10ps
`default_nettype none
module mac_arith
(
    mac_op_if.arith op
);
    typedef logic signed [mac_pkg::RESULT_W-1:0] wide_t;

    logic signed [mac_pkg::OPERAND_W:0]   x_ext;
    logic signed [mac_pkg::OPERAND_W:0]   y_ext;
    logic signed [2*mac_pkg::OPERAND_W+1:0] full_prod;
    logic [mac_pkg::RESULT_W-1:0]         prod_ext;
    logic [mac_pkg::RESULT_W-1:0]         combined;
    logic [mac_pkg::RESULT_W-1:0]         rounded;

    // One extra bit turns unsigned operands into positive signed ones [RULE8]
    assign x_ext = {op.signed_mode & op.multiplicand[mac_pkg::OPERAND_W-1],
                    op.multiplicand};
    assign y_ext = {op.signed_mode & op.multiplier[mac_pkg::OPERAND_W-1],
                    op.multiplier};
    assign full_prod = x_ext * y_ext;
    // Sign or zero extend into guard bits; -1 x -1 stays +1 [RULE19] [RULE21]
    assign prod_ext = wide_t'(full_prod);

    // Product minus register, product plus register, or plain product
    assign combined = !op.sum_mode ? prod_ext                   // [RULE3]
                    : op.diff_mode ? prod_ext - op.acc_value    // [RULE5] [RULE7]
                    : prod_ext + op.acc_value;                  // [RULE2] [RULE6] [RULE20]
    // Round adds at the lower section top bit, wraps mod 2^27 [RULE9] [RULE21]
    assign rounded = combined + (op.round_up ? mac_pkg::ROUND_ADD
                                             : mac_pkg::RESULT_RESET);
    assign op.next_value = rounded;
endmodule
`default_nettype wire

// File: mac_sync.sv
// Three-stage synchroniser with agreement filter for pin clocks
`timescale 1ns/10ps
`default_nettype none
module mac_sync
(
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst_b,
    // Pin in, filtered level and rising pulse out
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_rise
);
    logic [mac_pkg::SYNC_DEPTH-1:0] stage_reg;
    logic                           level_reg;
    logic                           agree;

    // Stage 0 is only read by stage 1
    always_ff @(posedge i_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            stage_reg <= '0;
            level_reg <= 1'b0;
        end
        else
        begin
            stage_reg <= {stage_reg[mac_pkg::SYNC_DEPTH-2:0], i_pin};
            if (agree)
                level_reg <= stage_reg[mac_pkg::SYNC_DEPTH-1];
        end
    end

    // A change counts once stages 1 and 2 agree
    assign agree   = stage_reg[mac_pkg::SYNC_DEPTH-2]
                     == stage_reg[mac_pkg::SYNC_DEPTH-1];
    assign o_rise  = agree & stage_reg[mac_pkg::SYNC_DEPTH-1] & ~level_reg;
    assign o_level = level_reg;
endmodule
`default_nettype wire

// File: mac_result_bus_host.sv
// Host side of the three-state result bus, resolving the pin levels
`timescale 1ns/10ps
`default_nettype none
module mac_result_bus_host
(
    // Clock
    input  wire logic                         i_clock,
    // Device side of the pins
    input  wire logic [mac_pkg::RESULT_W-1:0] i_dev_data,
    input  wire logic [mac_pkg::RESULT_W-1:0] i_dev_oe_b,
    // Host preload drive
    input  wire logic                         i_host_drive,
    input  wire logic [mac_pkg::RESULT_W-1:0] i_host_data,
    // Resolved pin levels
    output logic      [mac_pkg::RESULT_W-1:0] o_pins
);
    logic [mac_pkg::RESULT_W-1:0] float_reg = 27'h5555555;

    // Undriven bits flip each cycle so a stale value never looks valid
    always_ff @(posedge i_clock)
    begin
        float_reg <= ~float_reg;
    end

    // Device wins where enabled; elsewhere host drives preload data while i_host_drive is high, else the flipping float value
    assign o_pins = (~i_dev_oe_b & i_dev_data)
                  | (i_dev_oe_b & (i_host_drive ? i_host_data : float_reg));
endmodule
`default_nettype wire

// File: mac_12x12_accumulator_bench.sv
// Self-checking bench for the multiplier-accumulator
`timescale 1ns/10ps
`default_nettype none
module mac_12x12_accumulator_bench;
    logic        i_clock = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        xc = 1'b0, yc = 1'b0, pc = 1'b0;
    logic [11:0] x = 12'h000, y = 12'h000, xr = 12'h000, yr = 12'h000;
    logic        sum = 1'b0, diff = 1'b0, rnd = 1'b0, sgn = 1'b0;
    logic        pl = 1'b0, g = 1'b0, u = 1'b0, l = 1'b0, hdrv = 1'b0;
    logic [26:0] hdata = 27'h0000000, exp_reg = 27'h0000000;
    logic [26:0] pins, res, oe_b;
    int          err_count = 0, n_tests = 0, cyc = 0, seed;

    mac_12x12_accumulator uut (
        .i_clock(i_clock), .i_rst_b(i_rst_b),
        .i_multiplicand_clock(xc), .i_multiplier_clock(yc),
        .i_result_clock(pc), .i_multiplicand(x), .i_multiplier(y),
        .i_sum_mode_select(sum), .i_diff_select(diff),
        .i_round_up_select(rnd), .i_signed_select(sgn),
        .i_pin_load_mode(pl), .i_guard_out_disable(g),
        .i_upper_out_disable(u), .i_lower_out_disable(l),
        .i_result_pins(pins), .o_result(res), .o_result_oe_b(oe_b));

    mac_result_bus_host host (
        .i_clock(i_clock), .i_dev_data(res), .i_dev_oe_b(oe_b),
        .i_host_drive(hdrv), .i_host_data(hdata), .o_pins(pins));

    // Clock and hang guard
    always #4 i_clock = ~i_clock;
    always @(posedge i_clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("Checks %0d, errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(string what, logic [26:0] seen, logic [26:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Inputs always move 1 ns after the rising edge
    task automatic tick(int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    // Next register value; sign extension makes the mod 2^27 product right
    function automatic logic [26:0] calc(logic [11:0] a, logic [11:0] b,
        logic s, logic d, logic r, logic t, logic [26:0] q);
        logic [26:0] p;
        logic [26:0] n;
        p = t ? {{15{a[11]}}, a} * {{15{b[11]}}, b}
              : {15'h0000, a} * {15'h0000, b};
        n = s ? (d ? p - q : p + q) : p;
        if (r)
            n = n + 27'h0000800;
        return n;
    endfunction

    // One operation; mask bit 0 clocks X, bit 1 clocks Y
    task automatic mac_op(logic [11:0] a, logic [11:0] b, logic s,
        logic d, logic r, logic t, logic [1:0] m);
        x = a;
        y = b;
        {sum, diff, rnd, sgn} = {s, d, r, t};
        xc = m[0];
        yc = m[1];
        if (m[0])
            xr = a;
        if (m[1])
            yr = b;
        tick(5); // Held over capture
        xc = 1'b0;
        yc = 1'b0;
        // Garbage after capture must not leak into the result
        {x, y, sum, diff, rnd, sgn} = 28'($urandom);
        tick(3);
        pc = 1'b1;
        tick(5);
        pc = 1'b0;
        exp_reg = calc(xr, yr, s, d, r, t, exp_reg);
        check("result", res, exp_reg);
        check("pins", pins, exp_reg);
        tick(3);
    endtask

    // Preload the sections selected by {guard, upper, lower}
    task automatic preload(logic [26:0] d, logic [2:0] sel);
        logic [26:0] msk;
        msk = {{3{sel[2]}}, {12{sel[1]}}, {12{sel[0]}}};
        pl = 1'b1;
        {g, u, l} = sel;
        hdrv = 1'b1;
        hdata = d;
        tick(1);
        pc = 1'b1;
        tick(5);
        pc = 1'b0;
        tick(3);
        {pl, g, u, l, hdrv} = 5'h00;
        exp_reg = (d & msk) | (exp_reg & ~msk);
        tick(1);
        check("preload", res, exp_reg);
    endtask

    initial
    begin
        seed = $urandom(17);
        tick(4);
        i_rst_b = 1'b1;
        tick(3);
        check("reset", res, 27'h0000000);
        // Every preload and disable combination
        for (int k = 0; k < 16; k++)
        begin
            {pl, g, u, l} = k[3:0];
            tick(1);
            check("oe_b", oe_b, {{3{pl | g}}, {12{pl | u}}, {12{pl | l}}});
        end
        {pl, g, u, l} = 4'h0;
        tick(1);
        mac_op(12'h800, 12'h800, 1'b0, 1'b0, 1'b0, 1'b1, 2'h3);
        mac_op(12'hfff, 12'hfff, 1'b0, 1'b0, 1'b0, 1'b0, 2'h3);
        mac_op(12'hfff, 12'hfff, 1'b1, 1'b0, 1'b0, 1'b0, 2'h3);
        mac_op(12'h001, 12'h001, 1'b1, 1'b1, 1'b0, 1'b1, 2'h3);
        mac_op(12'h003, 12'h005, 1'b0, 1'b1, 1'b1, 1'b0, 2'h3);
        mac_op(12'h7ff, 12'h0aa, 1'b1, 1'b0, 1'b1, 1'b0, 2'h1);
        mac_op(12'h123, 12'h0aa, 1'b1, 1'b1, 1'b0, 1'b1, 2'h2);
        for (int k = 0; k < 8; k++)
            preload(27'($urandom), k[2:0]);
        for (int k = 0; k < 40; k++)
            mac_op(12'($urandom), 12'($urandom), 1'($urandom),
                   1'($urandom), 1'($urandom), 1'($urandom),
                   2'($urandom_range(1, 3)));
        end_sim();
    end
endmodule
`default_nettype wire
